// ### design/output_and_io_port_block.v
`timescale 1ns/1ps
`include "port_block_regs.vh"

module output_and_io_port_block #(
  parameter BUZZ_EN = 1,
  parameter BUZZ_JOINT = 0,
  parameter SERIAL_FLAG_EN = 1,
  parameter CLKOUT_EN = 1,
  parameter SERIAL_EN = 0,
  parameter [2:0] CLKOUT_DIV_LOG2 = 3'h7,
  parameter [2:0] BUZZ_DIV_LOG2 = 3'h3
) (
  input wire sys_clk,
  input wire rst,
  input wire clk_en,
  input wire [9:0] addr,
  input wire [3:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [3:0] rdata,
  input wire slow_osc_freq,
  input wire serial_run_flag,
  output reg [3:0] out_a_pins,
  output reg [3:0] out_b_pins,
  input wire [3:0] io_zero_in,
  output reg [3:0] io_zero_out,
  output reg [3:0] io_zero_oe,
  input wire [3:0] io_one_in,
  output reg [3:0] io_one_out,
  output reg [3:0] io_one_oe,
  output reg io_pull_down,
  output reg clock_timer_clear,
  output reg stopwatch_run,
  output reg stopwatch_clear,
  output reg osc_fast_on,
  output reg cpu_clock_select
);

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg [3:0] out_nibble_a_bits_r;
reg [3:0] out_b_r;
reg [3:0] io_nibble_zero_r;
reg [3:0] io_one_r;
reg dir_ctrl_zero_r;
reg dir_ctrl_one_r;
reg osc_s1_r;
reg osc_s2_r;
reg osc_d_r;
reg [7:0] div_r;
reg [1:0] pull_cnt_r;
reg [3:0] rd_nxt;
reg [3:0] out_b_nxt;
reg [3:0] io_zero_oe_nxt;
reg [3:0] io_one_oe_nxt;
wire [3:0] z_sync;
wire [3:0] o_sync;

// ----------------------------------------------------------------
// build-time options, folded to single-bit flags
// ----------------------------------------------------------------
// nonzero parameter selects the special function
wire buzz_on = (BUZZ_EN != 0);
wire buzz_joint = (BUZZ_JOINT != 0);
wire flag_on = (SERIAL_FLAG_EN != 0);
wire clkout_on = (CLKOUT_EN != 0);
wire serial_on = (SERIAL_EN != 0);
// pull-down load: whole cycles after the strobe cycle, minus one
localparam integer PULL_LOAD = `PULL_CYCLES - 1;

// ----------------------------------------------------------------
// derived strobes and waveforms
// ----------------------------------------------------------------
// slow oscillator rise, one sys_clk wide
wire osc_rise = osc_s2_r & ~osc_d_r;
wire buzz_wave = div_r[BUZZ_DIV_LOG2];
wire clk_wave = (CLKOUT_DIV_LOG2 == 3'h0) ? osc_s2_r :
  div_r[CLKOUT_DIV_LOG2 - 3'h1];
wire rd_hit_io = rd_stb &&
  (addr == `OFS_IO_ZERO || addr == `OFS_IO_ONE);

// ----------------------------------------------------------------
// address decode
// ----------------------------------------------------------------
wire wr_out_low = wr_stb && (addr == `OFS_OUT_LOW);
wire wr_out_high = wr_stb && (addr == `OFS_OUT_HIGH);
wire wr_io_zero = wr_stb && (addr == `OFS_IO_ZERO);
wire wr_io_one = wr_stb && (addr == `OFS_IO_ONE);
wire wr_tmr_dir = wr_stb && (addr == `OFS_TMR_DIR_ZERO);
wire wr_clk_dir = wr_stb && (addr == `OFS_CLK_DIR_ONE);

// ----------------------------------------------------------------
// pin synchronisers, two flops per io bit
// ----------------------------------------------------------------
genvar gi;
generate
  // each bit has its own pair; only the second flop is read
  for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin_sync
    reg z_s1_r;
    reg z_s2_r;
    reg o_s1_r;
    reg o_s2_r;
    always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        z_s1_r <= 1'b0;
        z_s2_r <= 1'b0;
        o_s1_r <= 1'b0;
        o_s2_r <= 1'b0;
      end else if (clk_en) begin
        z_s1_r <= io_zero_in[gi];
        z_s2_r <= z_s1_r;
        o_s1_r <= io_one_in[gi];
        o_s2_r <= o_s1_r;
      end
    end
    assign z_sync[gi] = z_s2_r;
    assign o_sync[gi] = o_s2_r;
  end
endgenerate

// ----------------------------------------------------------------
// slow oscillator synchroniser and divider
// ----------------------------------------------------------------
always @(posedge sys_clk or posedge rst) begin
  if (rst) begin
    osc_s1_r <= 1'b0;
    osc_s2_r <= 1'b0;
    osc_d_r <= 1'b0;
    div_r <= 8'h00;
  end else if (clk_en) begin
    osc_s1_r <= slow_osc_freq;
    osc_s2_r <= osc_s1_r;
    osc_d_r <= osc_s2_r;
    // one count per slow oscillator rise
    if (osc_rise) begin
      div_r <= div_r + 8'h01;
    end
  end
end

// ----------------------------------------------------------------
// read mux
// ----------------------------------------------------------------
always @* begin
  rd_nxt = 4'h0;
  case (addr)
    `OFS_OUT_LOW: rd_nxt = out_nibble_a_bits_r;
    `OFS_OUT_HIGH: begin
      rd_nxt = out_b_r;
      if (SERIAL_FLAG_EN != 0) begin
        rd_nxt[1] = serial_run_flag;
      end
    end
    `OFS_IO_ZERO: rd_nxt = z_sync;
    `OFS_IO_ONE: rd_nxt = o_sync;
    `OFS_TMR_DIR_ZERO: begin
      rd_nxt[`BIT_DIR] = dir_ctrl_zero_r;
      rd_nxt[`BIT_SWCLR] = 1'b0;
      rd_nxt[`BIT_STOPWATCH_RUN] = stopwatch_run;
      rd_nxt[`BIT_TMRCLR] = 1'b0;
    end
    `OFS_CLK_DIR_ONE: begin
      rd_nxt[`BIT_DIR] = dir_ctrl_one_r;
      rd_nxt[`BIT_OSC_ON] = osc_fast_on;
      rd_nxt[`BIT_CPU_SEL] = cpu_clock_select;
      rd_nxt[3] = 1'b0;
    end
    default: rd_nxt = 4'h0;
  endcase
end

// ----------------------------------------------------------------
// output port data
// ----------------------------------------------------------------
always @(posedge sys_clk or posedge rst) begin
  if (rst) begin
    out_nibble_a_bits_r <= `RST_NIBBLE;
    out_b_r <= `RST_NIBBLE;
  end else if (clk_en) begin
    if (wr_out_low) begin
      out_nibble_a_bits_r <= wdata;
    end
    if (wr_out_high) begin
      out_b_r[0] <= wdata[0];
      out_b_r[2] <= wdata[2];
      out_b_r[3] <= wdata[3];
      // status bit is read-only while the run flag owns it
      if (!flag_on) begin
        out_b_r[1] <= wdata[1];
      end
    end
  end
end

// ----------------------------------------------------------------
// io data latches, written in either direction
// ----------------------------------------------------------------
always @(posedge sys_clk or posedge rst) begin
  if (rst) begin
    io_nibble_zero_r <= `RST_NIBBLE;
    io_one_r <= `RST_NIBBLE;
  end else if (clk_en) begin
    if (wr_io_zero) begin
      io_nibble_zero_r <= wdata;
    end
    if (wr_io_one) begin
      io_one_r <= wdata;
    end
  end
end

// ----------------------------------------------------------------
// direction and shared control bits
// ----------------------------------------------------------------
always @(posedge sys_clk or posedge rst) begin
  if (rst) begin
    dir_ctrl_zero_r <= 1'b0;
    dir_ctrl_one_r <= 1'b0;
    stopwatch_run <= 1'b0;
    osc_fast_on <= 1'b0;
    cpu_clock_select <= 1'b0;
  end else if (clk_en) begin
    if (wr_tmr_dir) begin
      dir_ctrl_zero_r <= wdata[`BIT_DIR];
      stopwatch_run <= wdata[`BIT_STOPWATCH_RUN];
    end
    if (wr_clk_dir) begin
      dir_ctrl_one_r <= wdata[`BIT_DIR];
      osc_fast_on <= wdata[`BIT_OSC_ON];
      cpu_clock_select <= wdata[`BIT_CPU_SEL];
    end
  end
end

// ----------------------------------------------------------------
// one-cycle clear pulses
// ----------------------------------------------------------------
always @(posedge sys_clk or posedge rst) begin
  if (rst) begin
    clock_timer_clear <= 1'b0;
    stopwatch_clear <= 1'b0;
  end else if (clk_en) begin
    // pulses last one cycle: no write or a 0 drops them
    clock_timer_clear <= wr_tmr_dir & wdata[`BIT_TMRCLR];
    stopwatch_clear <= wr_tmr_dir & wdata[`BIT_SWCLR];
  end
end

// ----------------------------------------------------------------
// bus read data
// ----------------------------------------------------------------
always @(posedge sys_clk or posedge rst) begin
  if (rst) begin
    rdata <= 4'h0;
  end else if (clk_en) begin
    // data stand only in the cycle after the strobe
    rdata <= rd_stb ? rd_nxt : 4'h0;
  end
end

// ----------------------------------------------------------------
// read pull-down, 1.5 cycles rounded up to 2
// ----------------------------------------------------------------
// a fresh read reloads the count, so back-to-back reads extend it
always @(posedge sys_clk or posedge rst) begin
  if (rst) begin
    pull_cnt_r <= 2'h0;
    io_pull_down <= 1'b0;
  end else if (clk_en) begin
    if (rd_hit_io) begin
      // load counts the cycles after the first one
      pull_cnt_r <= PULL_LOAD[1:0];
      io_pull_down <= 1'b1;
    end else if (pull_cnt_r != 2'h0) begin
      pull_cnt_r <= pull_cnt_r - 2'h1;
    end else begin
      io_pull_down <= 1'b0;
    end
  end
end

// ----------------------------------------------------------------
// output port b: special functions per bit
// ----------------------------------------------------------------
always @* begin
  out_b_nxt = out_b_r;
  // bit 0: true buzzer gated by its own bit
  if (buzz_on) begin
    out_b_nxt[0] = out_b_r[0] & buzz_wave;
  end
  // bit 3: inverted buzzer, gated by bit 0 or bit 3
  if (buzz_on && buzz_joint) begin
    out_b_nxt[3] = out_b_r[0] & ~buzz_wave;
  end else if (buzz_on) begin
    out_b_nxt[3] = out_b_r[3] & ~buzz_wave;
  end
  // bit 1: serial run flag replaces the stored bit
  if (flag_on) begin
    out_b_nxt[1] = serial_run_flag;
  end
  // bit 2: divided clock gated by its bit, low otherwise
  if (clkout_on) begin
    out_b_nxt[2] = out_b_r[2] & clk_wave;
  end
end

// ----------------------------------------------------------------
// io output enables, one direction bit per nibble
// ----------------------------------------------------------------
always @* begin
  io_zero_oe_nxt = {4{dir_ctrl_zero_r}};
  io_one_oe_nxt = {4{dir_ctrl_one_r}};
  // serial pins belong to the serial block: never driven here
  if (serial_on) begin
    io_one_oe_nxt[2:0] = 3'h0;
  end
end

// ----------------------------------------------------------------
// output port pins
// ----------------------------------------------------------------
always @(posedge sys_clk or posedge rst) begin
  if (rst) begin
    out_a_pins <= 4'h0;
    out_b_pins <= 4'h0;
  end else if (clk_en) begin
    out_a_pins <= out_nibble_a_bits_r;
    out_b_pins <= out_b_nxt;
  end
end

// ----------------------------------------------------------------
// io pins
// ----------------------------------------------------------------
always @(posedge sys_clk or posedge rst) begin
  if (rst) begin
    io_zero_out <= 4'h0;
    io_zero_oe <= 4'h0;
    io_one_out <= 4'h0;
    io_one_oe <= 4'h0;
  end else if (clk_en) begin
    // latch reaches the pin unchanged; oe decides if it shows
    io_zero_out <= io_nibble_zero_r;
    io_zero_oe <= io_zero_oe_nxt;
    io_one_out <= io_one_r;
    io_one_oe <= io_one_oe_nxt;
  end
end

endmodule

// ### design/port_block_regs.vh
`ifndef PORT_BLOCK_REGS_VH
`define PORT_BLOCK_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_W 10
`define OFS_OUT_LOW 10'h2eb
`define OFS_OUT_HIGH 10'h2ec
`define OFS_IO_ZERO 10'h2ed
`define OFS_TMR_DIR_ZERO 10'h2ee
`define OFS_IO_ONE 10'h2fd
`define OFS_CLK_DIR_ONE 10'h2fe

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define BIT_DIR 0
`define BIT_STOPWATCH_RUN 2
`define BIT_TMRCLR 3
`define BIT_SWCLR 1
`define BIT_OSC_ON 1
`define BIT_CPU_SEL 2
`define RST_NIBBLE 4'h0

// ----------------------------------------------------------------
// timing: pull-down held 1.5 cycles, rounded up to whole cycles
// ----------------------------------------------------------------
`define PULL_HALF_CYCLES 3
`define PULL_CYCLES ((`PULL_HALF_CYCLES + 1) / 2)

`endif

// ### bench/port_block_sva.sv
`timescale 1ns/1ps
module port_block_sva (
  input wire sys_clk,
  input wire rst,
  input wire [9:0] addr,
  input wire [3:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  input wire [3:0] rdata,
  input wire serial_run_flag,
  input wire [3:0] out_a_pins,
  input wire [3:0] out_b_pins,
  input wire [3:0] io_zero_oe,
  input wire [3:0] io_one_out,
  input wire [3:0] io_one_oe,
  input wire io_pull_down
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire io_rd = rd_stb && (addr == 10'h2ed || addr == 10'h2fd);
  out_a_a:
    assert property (wr_stb && addr == 10'h2eb |-> ##2
      out_a_pins == $past(wdata, 2)) else $error("out a pins wrong");
  pull_len_a:
    assert property (io_rd |=> io_pull_down [*2])
      else $error("pull-down too short");
  pull_cause_a:
    assert property ($rose(io_pull_down) |-> $past(io_rd))
      else $error("pull-down without read");
  rdata_idle_a:
    assert property (!rd_stb |=> rdata == 4'h0) else $error("rdata not 0");
  flag_read_a:
    assert property (rd_stb && addr == 10'h2ec |=>
      rdata[1] == $past(serial_run_flag)) else $error("run flag wrong");
  buzz_pair_a:
    assert property (!(out_b_pins[0] && out_b_pins[3]))
      else $error("both buzzer pins high");
  dir_zero_a:
    assert property (wr_stb && addr == 10'h2ee |-> ##2
      io_zero_oe == {4{$past(wdata[0], 2)}}) else $error("oe wrong");
  io_drive_a:
    assert property (wr_stb && addr == 10'h2fd |-> ##2 (io_one_oe != 4'hf
      || io_one_out == $past(wdata, 2))) else $error("io out wrong");
  cover property (io_rd);
  cover property (out_b_pins[2]);
  cover property (wr_stb && addr == 10'h2ee && wdata[0]);
endmodule

// ### bench/pin_model.sv
`timescale 1ns/1ps
module pin_model (
  input wire sys_clk,
  input wire [3:0] oe,
  input wire [3:0] drv,
  input wire pull_down,
  input wire ext_en,
  input wire [3:0] ext_v,
  output wire [3:0] level
);
  reg [3:0] float_r = 4'h5;
  // undriven, unpulled pins wander every cycle
  always @(posedge sys_clk) float_r <= ~float_r;
  assign level = (oe & drv) | (~oe & (ext_en ? ext_v :
    pull_down ? 4'h0 : float_r));
endmodule

// ### bench/output_and_io_port_block_tb.sv
`timescale 1ns/1ps
module output_and_io_port_block_tb;
  reg sys_clk = 0, rst = 1, wr_stb = 0, rd_stb = 0, osc = 0, flag = 0;
  reg ext_en = 0;
  reg [9:0] addr = 0;
  reg [3:0] wdata = 0, ext = 0, r, d;
  integer seed = 32'h11d2, fail_count = 0, checks = 0, i, m, n, k;
  wire [3:0] rdata, oa, ob, z_in, z_out, z_oe, o_in, o_out, o_oe;
  wire pd;
  output_and_io_port_block dut (.sys_clk(sys_clk), .rst(rst),
    .clk_en(1'b1), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .slow_osc_freq(osc),
    .serial_run_flag(flag), .out_a_pins(oa), .out_b_pins(ob),
    .io_zero_in(z_in), .io_zero_out(z_out), .io_zero_oe(z_oe),
    .io_one_in(o_in), .io_one_out(o_out), .io_one_oe(o_oe),
    .io_pull_down(pd), .clock_timer_clear(), .stopwatch_run(),
    .stopwatch_clear(), .osc_fast_on(), .cpu_clock_select());
  pin_model p0 (.sys_clk(sys_clk), .oe(z_oe), .drv(z_out), .pull_down(pd),
    .ext_en(ext_en), .ext_v(ext), .level(z_in));
  pin_model p1 (.sys_clk(sys_clk), .oe(o_oe), .drv(o_out), .pull_down(pd),
    .ext_en(ext_en), .ext_v(ext), .level(o_in));
  // ----
  // bus tasks and checks
  // ----
  task chk(input string s, input [3:0] e, input [3:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("BAD %0s exp %h got %h", s, e, g);
      end
    end
  endtask
  task wr(input [9:0] a, input [3:0] v);
    begin
      @(posedge sys_clk);
      addr <= a;
      wdata <= v;
      wr_stb <= 1'b1;
      @(posedge sys_clk);
      wr_stb <= 1'b0;
    end
  endtask
  task rd(input [9:0] a);
    begin
      @(posedge sys_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge sys_clk);
      rd_stb <= 1'b0;
      #1 r = rdata;
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial forever #10 sys_clk = ~sys_clk;
  initial forever #40 osc = ~osc;
  initial begin
    #2000000 fail_count = fail_count + 1;
    end_sim;
  end
  // ----
  // main sequence
  // ----
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rd(10'h2eb); chk("out_a", 4'h0, r);
    chk("out_a_pins", 4'h0, oa);
    rd(10'h2ec); chk("out_b", 4'h0, r);
    rd(10'h2fe); chk("dir1", 4'h0, r);
    chk("oe0", 4'h0, z_oe | o_oe);
    rd(10'h2f0); chk("unmapped", 4'h0, r);
    for (i = 0; i < 12; i = i + 1) begin
      d = $random(seed);
      flag <= d[2];
      wr(10'h2eb, d); wr(10'h2ec, ~d);
      rd(10'h2ec); chk("out_b", {~d[3:2], d[2], ~d[0]}, r);
      chk("out_a_pins", d, oa);
      rd(10'h2eb); chk("out_a", d, r);
      for (m = 0; m < 2; m = m + 1) begin
        wr(m ? 10'h2fe : 10'h2ee, {d[3:1], 1'b0});
        wr(m ? 10'h2fd : 10'h2ed, d);
        ext <= ~d;
        ext_en <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd(m ? 10'h2fd : 10'h2ed); chk("io_in", ~d, r);
        ext_en <= 1'b0;
        wr(m ? 10'h2fe : 10'h2ee, 4'h1);
        rd(m ? 10'h2fe : 10'h2ee); chk("dir_rd", 4'h1, r);
        repeat (4) @(posedge sys_clk);
        rd(m ? 10'h2fd : 10'h2ed); chk("io_out", d, r);
        chk("io_oe", 4'hf, m ? o_oe : z_oe);
      end
    end
    wr(10'h2ec, 4'hf);
    repeat (3) @(posedge sys_clk);
    n = 0;
    k = 0;
    for (i = 0; i < 600; i = i + 1) begin
      @(posedge sys_clk);
      if (ob[3] !== ~ob[0]) n = n + 1;
      if (ob[2] === 1'b1) k = k + 1;
    end
    chk("bz_pair", 4'h0, {3'h0, n != 0});
    chk("divided_clock_out_run", 4'h1, {3'h0, k != 0});
    wr(10'h2ec, 4'h0);
    repeat (3) @(posedge sys_clk);
    for (i = 0; i < 600; i = i + 1) begin
      @(posedge sys_clk);
      if ((ob & 4'hd) !== 4'h0) n = n + 1;
    end
    chk("out_b_low", 4'h0, {3'h0, n != 0});
    end_sim;
  end
endmodule
bind output_and_io_port_block port_block_sva chk (.sys_clk(sys_clk),
  .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata(rdata), .serial_run_flag(serial_run_flag),
  .out_a_pins(out_a_pins), .out_b_pins(out_b_pins),
  .io_zero_oe(io_zero_oe), .io_one_out(io_one_out),
  .io_one_oe(io_one_oe), .io_pull_down(io_pull_down));
